// *** interrupt_priority_vectoring_test.sv ***
// self-checking bench for the interrupt priority and vectoring block
// assumes the cpu model answers offers and the checker is bound below
`timescale 1ns/10ps
module interrupt_priority_vectoring_test
	import ipv_pkg::*;
;
	logic clk = 1'h0, rst_n = 1'h0, ack_en = 1'h1, ret_req = 1'h0;
	logic [20:0] src = 21'h000000;
	logic [9:0]  vec_level_sel = 10'h3FF;
	logic [3:0]  ack_wait = 4'h1;
	logic ext_a_level_mode = 1'h0, ext_b_level_mode = 1'h0;
	logic wdt_reset = 1'h0, lvd_reset = 1'h0, reset_pin_n = 1'h1;
	logic halt_mode = 1'h0, hold_mode = 1'h0, xtal_hold_mode = 1'h0;
	logic irq_ack, irq_return, irq_valid, wake_halt, wake_hold;
	logic [15:0] irq_vector, taken_vec;
	logic [7:0]  taken_cnt;
	ipv_lvl_e    irq_level, active_level;
	int          errors = 0, num_checks = 0;
	// one source bit each: 0..13 same-clock, 14..19 pins a..f, 20 port0
	wire timer0_low_event = src[0], timer0_high_event = src[1];
	wire timer1_low_event = src[2], timer1_high_event = src[3];
	wire base_timer_event = src[4], sync_serial_a_event = src[5];
	wire sync_async_serial_b_event = src[6], full_duplex_serial_rx = src[7];
	wire full_duplex_serial_tx = src[8], adc_done_event = src[9];
	wire timer6_event = src[10], timer7_event = src[11];
	wire pwm_channel_a = src[12], pwm_channel_b = src[13];
	wire ext_pin_irq_a = src[14], ext_pin_irq_b = src[15];
	wire ext_pin_irq_c = src[16], ext_pin_irq_d = src[17];
	wire ext_pin_irq_e = src[18], ext_pin_irq_f = src[19];
	wire port0_irq = src[20];
	// expected vector slot of each source bit
	logic [3:0] vmap [21] = '{4'h2, 4'h4, 4'h5, 4'h5, 4'h3, 4'h6, 4'h7,
		4'h6, 4'h7, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h0, 4'h1, 4'h2, 4'h3,
		4'h2, 4'h3, 4'h9};
	always #2 clk = ~clk;
	ipv_controller i_ipv_controller (.*);
	ipv_cpu_model i_ipv_cpu_model (.*);

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_vec
	task automatic chk_lvl(input ipv_lvl_e got, input ipv_lvl_e exp);
		chk_vec({14'h0000, got}, {14'h0000, exp});
	endtask : chk_lvl
	task automatic chk_bit(input logic got, input logic exp);
		chk_vec({15'h0000, got}, {15'h0000, exp});
	endtask : chk_bit
	task automatic drive(input logic [20:0] v);
		@(posedge clk);
		src <= v;
	endtask : drive
	// watch one output for n cycles; which: 0 offer, 1 halt, 2 hold
	task automatic see(input int which, input int n, output logic got);
		got = 1'h0;
		repeat (n) begin
			@(posedge clk);
			#1;
			got = got | (which == 0 ? irq_valid :
				which == 1 ? wake_halt : wake_hold);
		end
	endtask : see
	// bounded wait for the cpu model to take an offer
	task automatic wait_take();
		logic [7:0] c0;
		int         i;
		c0 = taken_cnt;
		for (i = 0; i < 40 && taken_cnt === c0; i++) begin
			@(posedge clk);
			#1;
		end
		if (taken_cnt === c0) begin
			errors++;
			wrap_up();
		end else begin
			// step off the ack edge so the new service level has settled
			@(posedge clk);
			#1;
		end
	endtask : wait_take
	task automatic pulse_ret();
		@(posedge clk);
		ret_req <= 1'h1;
		@(posedge clk);
		ret_req <= 1'h0;
		repeat (3) @(posedge clk);
		#1;
	endtask : pulse_ret
	task automatic setup(input logic [9:0] s, input logic a);
		@(posedge clk);
		vec_level_sel <= s;
		ack_en <= a;
		repeat (2) @(posedge clk);
	endtask : setup

	// ****************************************************************
	// scenarios
	// ****************************************************************
	// every source alone: vector, level, refusal at equal level, return
	task automatic sc_map();
		logic     got;
		ipv_lvl_e el;
		for (int i = 0; i < 21; i++) begin
			drive(21'h000001 << i);
			wait_take();
			el = (vmap[i] < 4'h2) ? IPV_LVL_TOP : IPV_LVL_HIGH;
			chk_vec(taken_vec, 16'h0003 + {vmap[i], 3'h0});
			chk_lvl(active_level, el);
			see(0, 5, got);
			chk_bit(got, 1'h0);
			drive(21'h000000);
			repeat (8) @(posedge clk);
			pulse_ret();
			chk_lvl(active_level, IPV_LVL_NONE);
		end
	endtask : sc_map
	// level beats address, address breaks ties, nesting and unwinding
	task automatic sc_prio();
		logic got;
		setup(10'h020, 1'h0);
		drive(21'h000005);
		see(0, 3, got);
		chk_vec(irq_vector, 16'h002B);
		chk_lvl(irq_level, IPV_LVL_HIGH);
		drive(21'h000000);
		setup(10'h3FF, 1'h0);
		drive(21'h000005);
		see(0, 3, got);
		chk_vec(irq_vector, 16'h0013);
		chk_lvl(irq_level, IPV_LVL_HIGH);
		@(posedge clk);
		ack_en <= 1'h1;
		wait_take();
		drive(21'h004005);
		wait_take();
		chk_vec(taken_vec, 16'h0003);
		chk_lvl(active_level, IPV_LVL_TOP);
		drive(21'h000005);
		repeat (8) @(posedge clk);
		pulse_ret();
		chk_lvl(active_level, IPV_LVL_HIGH);
		drive(21'h000000);
		pulse_ret();
		chk_lvl(active_level, IPV_LVL_NONE);
	endtask : sc_prio
	// halt ends on watchdog, low voltage, reset pin and a request
	task automatic sc_halt();
		logic got;
		@(posedge clk);
		halt_mode <= 1'h1;
		see(1, 6, got);
		chk_bit(got, 1'h0);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			wdt_reset <= (k == 0);
			lvd_reset <= (k == 1);
			reset_pin_n <= (k != 2);
			src <= (k == 3) ? 21'h000002 : 21'h000000;
			see(1, 8, got);
			chk_bit(got, 1'h1);
			drive(21'h000000);
			wdt_reset <= 1'h0;
			lvd_reset <= 1'h0;
			reset_pin_n <= 1'h1;
			repeat (8) @(posedge clk);
			pulse_ret();
		end
		@(posedge clk);
		halt_mode <= 1'h0;
		wdt_reset <= 1'h1;
		see(1, 4, got);
		chk_bit(got, 1'h0);
		@(posedge clk);
		wdt_reset <= 1'h0;
	endtask : sc_halt
	// deep standby wake sources, level-sense gate, crystal base timer
	task automatic sc_hold();
		int          wbit [11] = '{17, 1, 4, 4, 14, 14, 15, 16, 18, 19, 20};
		logic [10:0] wmode = 11'h7E0;
		logic [10:0] wx = 11'h008;
		logic [10:0] wexp = 11'h7E8;
		logic        got;
		@(posedge clk);
		ack_en <= 1'h0;
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			hold_mode <= !wx[i];
			xtal_hold_mode <= wx[i];
			ext_a_level_mode <= wmode[i];
			ext_b_level_mode <= wmode[i];
			drive(21'h000001 << wbit[i]);
			see(2, 10, got);
			chk_bit(got, wexp[i]);
			drive(21'h000000);
			hold_mode <= 1'h0;
			xtal_hold_mode <= 1'h0;
			repeat (8) @(posedge clk);
		end
	endtask : sc_hold

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		sc_map();
		sc_prio();
		sc_halt();
		sc_hold();
		wrap_up();
	end
endmodule : interrupt_priority_vectoring_test

bind ipv_controller ipv_chk i_ipv_chk (.*);

// *** ipv_arb_if.sv ***
// carrier between the controller and its arbiter
// assumes both ends share one clock; the bundle is purely combinational
`timescale 1ns/10ps
interface ipv_arb_if;
	import ipv_pkg::*;
	logic     [`IPV_NUM_VECTORS-1:0] req;
	ipv_lvl_e                        lvl [`IPV_NUM_VECTORS];
	ipv_lvl_e                        floor;
	logic                            found;
	ipv_idx_t                        idx;
	ipv_lvl_e                        win_lvl;

	modport arb (input req, lvl, floor, output found, idx, win_lvl);
	modport ctl (output req, lvl, floor, input found, idx, win_lvl);
endinterface : ipv_arb_if

// *** ipv_arbiter.sv ***
// level-then-address arbiter over the ten vectors
// assumes the floor is the level now in service; purely combinational
`timescale 1ns/10ps
module ipv_arbiter
	import ipv_pkg::*;
(
	// request bundle
	ipv_arb_if.arb a
);
	// ****************************************************************
	// selection
	// ****************************************************************
	// walk down so an equal level later in the walk means smaller address
	always_comb begin
		ipv_lvl_e best;
		best      = a.floor;
		a.found   = 1'b0;
		a.idx     = '0;
		a.win_lvl = IPV_LVL_NONE;
		for (int i = `IPV_NUM_VECTORS - 1; i >= 0; i--) begin
			if (a.req[i] && (a.lvl[i] > a.floor) &&
			    (a.lvl[i] >= best)) begin // RULE_02 RULE_03 RULE_04
				best      = a.lvl[i];
				a.found   = 1'b1;
				a.idx     = ipv_idx_t'(i);
				a.win_lvl = a.lvl[i];
			end
		end
	end
endmodule : ipv_arbiter

// *** ipv_chk.sv ***
// checker for the interrupt priority and vectoring block
// assumes a bind onto ipv_controller; sees only its ports
`timescale 1ns/10ps
module ipv_chk
	import ipv_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// requests and setup
	input wire logic        timer0_high_event,
	input wire logic        base_timer_event,
	input wire logic [9:0]  vec_level_sel,
	input wire logic        wdt_reset,
	input wire logic        lvd_reset,
	input wire logic        halt_mode,
	input wire logic        hold_mode,
	input wire logic        xtal_hold_mode,
	// cpu handshake
	input wire logic        irq_ack,
	input wire logic        irq_return,
	input wire logic        irq_valid,
	input wire logic [15:0] irq_vector,
	input wire ipv_lvl_e    irq_level,
	input wire ipv_lvl_e    active_level,
	input wire logic        wake_halt,
	input wire logic        wake_hold
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// vector slot from the address; step of eight from 0003H
	wire      [3:0] vi = irq_vector[6:3];
	ipv_lvl_e       exp_lvl;
	assign exp_lvl = !vec_level_sel[vi] ? IPV_LVL_LOW :
		(vi < 4'h2) ? IPV_LVL_TOP : IPV_LVL_HIGH;
	sequence s_take;
		irq_valid && irq_ack && !irq_return;
	endsequence
	sequence s_halt_cause;
		halt_mode && (wdt_reset || lvd_reset);
	endsequence
	a_offer_above:
		assert property (irq_valid |-> irq_level > active_level)
		else $error("offer not above service level");
	a_take_level:
		assert property (s_take |=> !irq_valid &&
			active_level == $past(irq_level))
		else $error("taken offer did not set service level");
	a_level_sel:
		assert property (irq_valid |-> irq_level == exp_lvl)
		else $error("offered level disagrees with select");
	a_idle_vec:
		assert property (!irq_valid |-> irq_vector == 16'h0000)
		else $error("vector shown without offer");
	a_timer0_map:
		assert property ($rose(irq_valid) && irq_vector == 16'h0023
			|-> $past(timer0_high_event))
		else $error("0023H offered without its source");
	a_offer_frozen:
		assert property (irq_valid && !irq_ack |=> !irq_valid ||
			$stable(irq_vector))
		else $error("standing offer changed vector");
	a_halt_cause:
		assert property (s_halt_cause |=> wake_halt)
		else $error("system reset did not end halt");
	a_halt_gated:
		assert property (!halt_mode |=> !wake_halt)
		else $error("halt wake outside halt");
	a_hold_gated:
		assert property (!hold_mode && !xtal_hold_mode |=> !wake_hold)
		else $error("standby wake outside standby");
	a_xtal_base:
		assert property (xtal_hold_mode && base_timer_event |=> wake_hold)
		else $error("base timer did not wake crystal standby");
	a_return_lvl:
		assert property (irq_return && !irq_ack &&
			active_level != IPV_LVL_NONE |=> active_level < $past(active_level))
		else $error("return did not lower service level");
endmodule : ipv_chk

// *** ipv_controller.sv ***
// Contract
// [RULE_01] twenty sources fold onto ten vectors, sharers ORed into one request; the code folds twenty-one sources
// [RULE_02] three levels; requests at or below the serviced level are refused
// [RULE_03] among pending vectors the highest level wins, top over high over low
// [RULE_04] at equal level the smallest vector address wins
// [RULE_05] pin a at 00003H, pin b at 0000BH, each top or low
// [RULE_06] 00013H: pins c,e, timer0 low; 0001BH: pins d,f, base timer
// [RULE_07] 00023H timer0 high, 0002BH timer1, 00033H receive, 0003BH transmit
// [RULE_08] 00043H converter, timers 6,7, pwm; 0004BH port0 change
// [RULE_09] halt ends on an accepted request, reset pin, watchdog or low voltage
// [RULE_10] deep standby wakes only on pins a,b,c,e,f or port0
// [RULE_11] pins a and b wake deep standby only in level-sense mode
// [RULE_12] crystal-retaining standby also wakes on the base timer
// [RULE_13] returning from service restores the previously active level
//
// top of the interrupt priority and vectoring block
// assumes peripheral flags stay set until software clears them, and that
// the cpu sequencer answers an offer with a one-cycle acknowledge
`timescale 1ns/10ps
module ipv_controller
	import ipv_pkg::*;
(
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	// external pin requests, asynchronous
	input  wire logic                         ext_pin_irq_a,
	input  wire logic                         ext_pin_irq_b,
	input  wire logic                         ext_pin_irq_c,
	input  wire logic                         ext_pin_irq_d,
	input  wire logic                         ext_pin_irq_e,
	input  wire logic                         ext_pin_irq_f,
	input  wire logic                         port0_irq,
	input  wire logic                         reset_pin_n,
	// peripheral requests, on clk
	input  wire logic                         timer0_low_event,
	input  wire logic                         timer0_high_event,
	input  wire logic                         timer1_low_event,
	input  wire logic                         timer1_high_event,
	input  wire logic                         base_timer_event,
	input  wire logic                         sync_serial_a_event,
	input  wire logic                         sync_async_serial_b_event,
	input  wire logic                         full_duplex_serial_rx,
	input  wire logic                         full_duplex_serial_tx,
	input  wire logic                         adc_done_event,
	input  wire logic                         timer6_event,
	input  wire logic                         timer7_event,
	input  wire logic                         pwm_channel_a,
	input  wire logic                         pwm_channel_b,
	// configuration, on clk
	input  wire logic [`IPV_NUM_VECTORS-1:0]  vec_level_sel,
	input  wire logic                         ext_a_level_mode,
	input  wire logic                         ext_b_level_mode,
	// system resets that end halt, on clk
	input  wire logic                         wdt_reset,
	input  wire logic                         lvd_reset,
	// standby modes from the core
	input  wire logic                         halt_mode,
	input  wire logic                         hold_mode,
	input  wire logic                         xtal_hold_mode,
	// cpu sequencer handshake
	input  wire logic                         irq_ack,
	input  wire logic                         irq_return,
	output logic                              irq_valid,
	output logic      [`IPV_VEC_W-1:0]        irq_vector,
	output ipv_lvl_e                          irq_level,
	output ipv_lvl_e                          active_level,
	output logic                              wake_halt,
	output logic                              wake_hold
);
	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [`IPV_PIN_W-1:0] pin_raw;
	logic [`IPV_PIN_W-1:0] pin_s;

	// reset pin inverted ahead of the first stage, so all bits reset low
	assign pin_raw[`IPV_PIN_A]     = ext_pin_irq_a;
	assign pin_raw[`IPV_PIN_B]     = ext_pin_irq_b;
	assign pin_raw[`IPV_PIN_C]     = ext_pin_irq_c;
	assign pin_raw[`IPV_PIN_D]     = ext_pin_irq_d;
	assign pin_raw[`IPV_PIN_E]     = ext_pin_irq_e;
	assign pin_raw[`IPV_PIN_F]     = ext_pin_irq_f;
	assign pin_raw[`IPV_PIN_PORT0] = port0_irq;
	assign pin_raw[`IPV_PIN_RESET] = ~reset_pin_n;

	ipv_pin_sync #(
		.W         (`IPV_PIN_W)
	) u_sync (
		.clk       (clk),
		.rst_n     (rst_n),
		.pin_async (pin_raw),
		.pin_sync  (pin_s)
	);

	wire pin_a     = pin_s[`IPV_PIN_A];
	wire pin_b     = pin_s[`IPV_PIN_B];
	wire pin_c     = pin_s[`IPV_PIN_C];
	wire pin_d     = pin_s[`IPV_PIN_D];
	wire pin_e     = pin_s[`IPV_PIN_E];
	wire pin_f     = pin_s[`IPV_PIN_F];
	wire pin_port0 = pin_s[`IPV_PIN_PORT0];
	wire pin_reset = pin_s[`IPV_PIN_RESET];

	// ****************************************************************
	// source to vector folding
	// ****************************************************************
	logic [`IPV_NUM_VECTORS-1:0] vec_req;

	// shared vectors see the OR of their sources; software sorts them out
	assign vec_req[0] = pin_a;                                    // RULE_05
	assign vec_req[1] = pin_b;                                    // RULE_05
	assign vec_req[2] = pin_c | pin_e | timer0_low_event;         // RULE_06
	assign vec_req[3] = pin_d | pin_f | base_timer_event;         // RULE_06
	assign vec_req[4] = timer0_high_event;                        // RULE_07
	assign vec_req[5] = timer1_low_event | timer1_high_event;     // RULE_07
	assign vec_req[6] = sync_serial_a_event | full_duplex_serial_rx; // RULE_07
	assign vec_req[7] = sync_async_serial_b_event
	                  | full_duplex_serial_tx;                    // RULE_07
	assign vec_req[8] = adc_done_event | timer6_event | timer7_event
	                  | pwm_channel_a | pwm_channel_b;            // RULE_08 RULE_01
	assign vec_req[9] = pin_port0;                                // RULE_08

	// ****************************************************************
	// per-vector levels
	// ****************************************************************
	ipv_lvl_e vec_lvl [`IPV_NUM_VECTORS];

	// the two pin vectors choose top or low, the rest high or low
	genvar g;
	generate
		for (g = 0; g < `IPV_NUM_VECTORS; g++) begin : g_lvl
			if (g < 2) begin : g_pin
				assign vec_lvl[g] = vec_level_sel[g] ? IPV_LVL_TOP
				                                     : IPV_LVL_LOW; // RULE_05
			end else begin : g_per
				assign vec_lvl[g] = vec_level_sel[g] ? IPV_LVL_HIGH
				                                     : IPV_LVL_LOW; // RULE_06
			end
		end
	endgenerate

	// ****************************************************************
	// in-service tracking
	// ****************************************************************
	// one bit per level is enough: a level nests only above itself, so
	// the in-service set is always a strictly ordered stack
	logic [2:0] in_svc_reg;
	logic [2:0] in_svc_next;
	logic [2:0] svc_top_mask;
	logic [2:0] svc_set_mask;
	ipv_lvl_e   cur_level;

	assign cur_level = in_svc_reg[2] ? IPV_LVL_TOP  :
	                   in_svc_reg[1] ? IPV_LVL_HIGH :
	                   in_svc_reg[0] ? IPV_LVL_LOW  : IPV_LVL_NONE;

	// return drops only the newest level, uncovering the one beneath
	assign svc_top_mask = in_svc_reg[2] ? 3'h4 :
	                      in_svc_reg[1] ? 3'h2 :
	                      in_svc_reg[0] ? 3'h1 : 3'h0;            // RULE_13

	// ****************************************************************
	// arbitration
	// ****************************************************************
	ipv_arb_if arb_bus ();

	assign arb_bus.req   = vec_req;
	assign arb_bus.lvl   = vec_lvl;
	assign arb_bus.floor = cur_level;                              // RULE_02

	ipv_arbiter u_arb (
		.a (arb_bus)
	);

	// vector address by index, smaller index is smaller address
	function automatic logic [`IPV_VEC_W-1:0] vec_addr(input ipv_idx_t i);
		unique case (i)
			4'h0:    vec_addr = `IPV_VEC_0;
			4'h1:    vec_addr = `IPV_VEC_1;
			4'h2:    vec_addr = `IPV_VEC_2;
			4'h3:    vec_addr = `IPV_VEC_3;
			4'h4:    vec_addr = `IPV_VEC_4;
			4'h5:    vec_addr = `IPV_VEC_5;
			4'h6:    vec_addr = `IPV_VEC_6;
			4'h7:    vec_addr = `IPV_VEC_7;
			4'h8:    vec_addr = `IPV_VEC_8;
			4'h9:    vec_addr = `IPV_VEC_9;
			default: vec_addr = `IPV_VEC_IDLE;
		endcase
	endfunction : vec_addr

	// ****************************************************************
	// offer state machine
	// ****************************************************************
	ipv_state_e            state_reg;
	ipv_state_e            state_next;
	ipv_idx_t              offer_idx_reg;
	ipv_idx_t              offer_idx_next;
	ipv_lvl_e              offer_lvl_reg;
	ipv_lvl_e              offer_lvl_next;
	logic                  take;
	logic                  withdrawn;

	assign take      = (state_reg == IPV_ST_OFFER) && irq_ack;
	// a source cleared before the ack must not be vectored to
	assign withdrawn = (state_reg == IPV_ST_OFFER) && !irq_ack &&
	                   !vec_req[offer_idx_reg];

	always_comb begin
		state_next     = state_reg;
		offer_idx_next = offer_idx_reg;
		offer_lvl_next = offer_lvl_reg;
		unique case (state_reg)
			IPV_ST_IDLE: begin
				if (arb_bus.found) begin
					state_next     = IPV_ST_OFFER;
					offer_idx_next = arb_bus.idx;              // RULE_04
					offer_lvl_next = arb_bus.win_lvl;          // RULE_03
				end
			end
			IPV_ST_OFFER: begin
				if (take || withdrawn) begin
					state_next = IPV_ST_IDLE;
				end
			end
		endcase
	end

	// the taken offer's level joins the in-service set
	always_comb begin
		svc_set_mask = 3'h0;
		if (take) begin
			unique case (offer_lvl_reg)
				IPV_LVL_TOP:  svc_set_mask = 3'h4;
				IPV_LVL_HIGH: svc_set_mask = 3'h2;
				IPV_LVL_LOW:  svc_set_mask = 3'h1;
				IPV_LVL_NONE: svc_set_mask = 3'h0;
			endcase
		end
	end

	// a return and a new entry in one cycle both apply
	assign in_svc_next = (in_svc_reg & ~(irq_return ? svc_top_mask : 3'h0))
	                   | svc_set_mask;                              // RULE_13

	// ****************************************************************
	// wake requests
	// ****************************************************************
	logic wake_halt_next;
	logic wake_hold_next;
	logic pin_wake;

	// pins a and b only wake deep standby in level-sense mode
	assign pin_wake = (pin_a & ext_a_level_mode)
	                | (pin_b & ext_b_level_mode)                   // RULE_11
	                | pin_c | pin_e | pin_f | pin_port0;           // RULE_10

	assign wake_halt_next = halt_mode &
	                        (arb_bus.found | pin_reset |
	                         wdt_reset | lvd_reset);                // RULE_09
	assign wake_hold_next = (hold_mode & pin_wake) |
	                        (xtal_hold_mode &
	                         (pin_wake | base_timer_event));       // RULE_12

	// ****************************************************************
	// registers
	// ****************************************************************
	// state and in-service set
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg     <= IPV_ST_IDLE;
			offer_idx_reg <= '0;
			offer_lvl_reg <= IPV_LVL_NONE;
			in_svc_reg    <= `IPV_SVC_RST;
		end else begin
			state_reg     <= state_next;
			offer_idx_reg <= offer_idx_next;
			offer_lvl_reg <= offer_lvl_next;
			in_svc_reg    <= in_svc_next;                          // RULE_02
		end
	end

	// outputs, each straight from a flip-flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_valid    <= 1'b0;
			irq_vector   <= `IPV_VEC_IDLE;
			irq_level    <= IPV_LVL_NONE;
			active_level <= IPV_LVL_NONE;
			wake_halt    <= 1'b0;
			wake_hold    <= 1'b0;
		end else begin
			irq_valid    <= (state_next == IPV_ST_OFFER);
			irq_vector   <= (state_next == IPV_ST_OFFER) ?
			                vec_addr(offer_idx_next) : `IPV_VEC_IDLE;
			irq_level    <= (state_next == IPV_ST_OFFER) ?
			                offer_lvl_next : IPV_LVL_NONE;
			active_level <= in_svc_next[2] ? IPV_LVL_TOP  :
			                in_svc_next[1] ? IPV_LVL_HIGH :
			                in_svc_next[0] ? IPV_LVL_LOW  : IPV_LVL_NONE;
			wake_halt    <= wake_halt_next;
			wake_hold    <= wake_hold_next;
		end
	end
endmodule : ipv_controller

// *** ipv_cpu_model.sv ***
// cpu sequencer model: takes offers after a set wait, pulses return
// assumes the controller holds each offer until it is acknowledged or its source clears
`timescale 1ns/10ps
module ipv_cpu_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// bench controls
	input  wire logic        ack_en,
	input  wire logic [3:0]  ack_wait,
	input  wire logic        ret_req,
	// controller side
	input  wire logic        irq_valid,
	input  wire logic [15:0] irq_vector,
	output logic             irq_ack,
	output logic             irq_return,
	// what was taken
	output logic      [15:0] taken_vec,
	output logic      [7:0]  taken_cnt
);
	logic [3:0] wait_reg;
	// no ack in the cycle after one: the offer is still shown then
	always_ff @(posedge clk) begin
		irq_ack <= 1'h0;
		irq_return <= ret_req & rst_n;
		if (!rst_n) begin
			wait_reg <= 4'h0;
			taken_cnt <= 8'h00;
			taken_vec <= 16'h0000;
		end else if (!irq_valid || irq_ack || !ack_en) begin
			wait_reg <= 4'h0;
		end else if (wait_reg == ack_wait) begin
			irq_ack <= 1'h1;
			taken_vec <= irq_vector;
			taken_cnt <= taken_cnt + 8'h01;
		end else begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule : ipv_cpu_model

// *** ipv_params.svh ***
// constants of the interrupt priority and vectoring block
// assumes inclusion by bare name from the package only; the design modules use its macros through it
`ifndef IPV_PARAMS_SVH
`define IPV_PARAMS_SVH

// ****************************************************************
// vector table
// ****************************************************************
`define IPV_NUM_VECTORS 10
`define IPV_VEC_W       16
`define IPV_VEC_0       16'h0003
`define IPV_VEC_1       16'h000B
`define IPV_VEC_2       16'h0013
`define IPV_VEC_3       16'h001B
`define IPV_VEC_4       16'h0023
`define IPV_VEC_5       16'h002B
`define IPV_VEC_6       16'h0033
`define IPV_VEC_7       16'h003B
`define IPV_VEC_8       16'h0043
`define IPV_VEC_9       16'h004B
`define IPV_VEC_IDLE    16'h0000

// ****************************************************************
// pin synchroniser layout and reset values
// ****************************************************************
`define IPV_PIN_W       8
`define IPV_PIN_RST     1'h0
`define IPV_PIN_A       0
`define IPV_PIN_B       1
`define IPV_PIN_C       2
`define IPV_PIN_D       3
`define IPV_PIN_E       4
`define IPV_PIN_F       5
`define IPV_PIN_PORT0   6
`define IPV_PIN_RESET   7
`define IPV_SVC_RST     3'h0

`endif

// *** ipv_pin_sync.sv ***
// three-stage synchroniser for asynchronous pin levels
// assumes inputs come from outside the clk domain
`timescale 1ns/10ps
module ipv_pin_sync
	import ipv_pkg::*;
#(
	parameter int W = `IPV_PIN_W
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// levels
	input  wire logic [W-1:0] pin_async,
	output logic      [W-1:0] pin_sync
);
	// ****************************************************************
	// per-bit chain
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic out_reg;
			// a change counts only once the second and third stage agree
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					s1_reg  <= `IPV_PIN_RST;
					s2_reg  <= `IPV_PIN_RST;
					s3_reg  <= `IPV_PIN_RST;
					out_reg <= `IPV_PIN_RST;
				end else begin
					s1_reg <= pin_async[g];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg) begin
						out_reg <= s3_reg;
					end
				end
			end
			assign pin_sync[g] = out_reg;
		end
	endgenerate
endmodule : ipv_pin_sync

// *** ipv_pkg.sv ***
// types shared by the interrupt priority and vectoring modules
// assumes ipv_params.svh is on the include path
package ipv_pkg;
	`include "ipv_params.svh"

	// ordered so that a plain compare ranks the levels
	typedef enum logic [1:0] {
		IPV_LVL_NONE,
		IPV_LVL_LOW,
		IPV_LVL_HIGH,
		IPV_LVL_TOP
	} ipv_lvl_e;

	// offer state toward the cpu sequencer
	typedef enum logic {
		IPV_ST_IDLE,
		IPV_ST_OFFER
	} ipv_state_e;

	typedef logic [3:0] ipv_idx_t;
endpackage : ipv_pkg
